// *** shared/tisp_pkg.sv ***
/*
 * Shared constants and types for the TMDS input selector and test-pattern block.
 * Assumes byte-wide registers reached over a two-wire serial port at byte offsets.
 */
package tisp_pkg;
    // Register offsets.
    localparam logic [7:0] REG_CTRL = 8'h02;
    localparam logic [7:0] REG_CFG  = 8'h03;
    localparam logic [7:0] REG_EQAB = 8'h07;
    localparam logic [7:0] REG_EQCD = 8'h08;
    localparam logic [7:0] REG_TPG  = 8'h09;
    localparam logic [7:0] REG_ERR0 = 8'h0a;
    localparam logic [7:0] REG_ERR1 = 8'h0b;
    localparam logic [7:0] REG_ERR2 = 8'h0c;
    localparam logic [7:0] REG_PLL  = 8'h10;
    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h08;
    localparam logic [7:0] CFG_RST  = 8'h10;
    localparam logic [7:0] EQ_RST   = 8'hcc;
    localparam logic [7:0] TPG_RST  = 8'h00;
    localparam logic [7:0] PLL_RST  = 8'h10;
    // Field positions.
    localparam int CTRL_AUTO_BIT  = 2;
    localparam int CTRL_HWSEL_BIT = 3;
    localparam int CTRL_PD_BIT    = 5;
    localparam int CFG_ACT_BIT    = 4;
    localparam int TPG_ERR_EN_BIT = 2;
    localparam logic [7:0] ERR_MAX = 8'hff;
    // Generator modes and the slow toggle period.
    localparam logic [1:0] GEN_NORMAL = 2'h0;
    localparam logic [1:0] GEN_PRBS   = 2'h1;
    localparam logic [1:0] GEN_LOW    = 2'h2;
    localparam logic [1:0] GEN_HIGH   = 2'h3;
    localparam logic [3:0] LOW_HALF   = 4'h5;
    localparam logic [3:0] LOW_LAST   = 4'h9;
    localparam logic [6:0] PRBS_SEED  = 7'h7f;

    typedef enum logic [3:0] {I_IDLE, I_ADDR, I_AACK, I_REG, I_REGACK, I_WDATA, I_WACK, I_RDATA, I_MACK} tisp_i2c_t;

    typedef struct packed {
        logic       scl_s1, scl_s2, scl_d;
        logic       sda_s1, sda_s2, sda_d;
        logic       auto_s1, auto_s2, pd_s1, pd_s2;
        logic [1:0] chsel_s1, chsel_s2;
        logic [3:0] act_s1, act_s2, cm_s1, cm_s2;
        logic [2:0] tg_s1, tg_s2, tg_d;
        tisp_i2c_t  st;
        logic [3:0] bitcnt;
        logic [7:0] sh, ptr;
        logic       rw, nack, sda_oe, sda_o;
        logic [7:0] ctrl, cfg, eq_ab, eq_cd, tpg, pll;
        logic [2:0][7:0] errcnt;
        logic [1:0] sel, chsel_out;
        logic       sel_valid, chsel_oe, pd;
    } tisp_sys_t;

    typedef struct packed {
        logic [1:0] rs;
        logic [1:0] mode_s1, mode_s2, mode_d, mode;
        logic       en_s1, en_s2;
        logic [6:0] prbs;
        logic [3:0] lowcnt;
        logic       hf;
        logic [2:0][6:0] hist;
        logic [2:0] err_tg, tx;
    } tisp_link_t;
endpackage

// *** design/tisp_top.sv ***
/*
 * Input selection, register file, test pattern generator and lane error counters.
 * Assumes link_clk is the currently selected channel's TMDS clock and that rx_lane
 * carries recovered bits aligned to it; analog activity flags arrive asynchronously.
 */
// Functional notes
// - Four-bit equalizer gain per channel, two per register, reset to twelve.
// - Generator mode: 0 pass-through, 1 PRBS7, 2 five/five toggle, 3 alternating.
// - Patterns are clocked from the selected channel's clock, 25 to 165 MHz.
// - Error counters count only while the enable bit of the pattern register is set.
// - Three eight-bit read-only error counters that saturate at all ones.
// - Reading an error counter returns it, then clears it when the read completes.
// - Two-bit loop bandwidth field, 0 is 4 MHz at reset, 3 is 500 kHz.
// - Multiplexer is built with four or two inputs; one input has no selection.
// - After reset selection follows the auto-select and channel-select pins.
// - Auto mode routes lowest-numbered active channel, A first; none active means inactive.
// - In hardware auto mode the channel-select pins report the selected channel.
// - Channel-select pin level is undefined during power-down.
// - Auto pin low: board drives channel-select pins and that channel is routed.
// - Clearing hardware-select bit hands the multiplexer to software.
// - Software auto and channel bits act like the external pins, except the channel bits still report status during power-down.
// - Software auto: channel bits read-only status; software manual: they select.
// - Activity from clock toggling when mode bit is 0, common-mode level when 1.
`timescale 1ns/1ps
module tisp_top
    import tisp_pkg::*;
#(
    parameter int         NUM_CH   = 4,
    parameter logic [6:0] I2C_ADDR = 7'h50
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        scl,
    input  wire logic        sda_in,
    output      logic        sda_out,
    output      logic        sda_oe,
    input  wire logic        auto_select_pin,
    input  wire logic        power_down_pin,
    input  wire logic [1:0]  channel_select_pins_in,
    output      logic [1:0]  channel_select_pins_out,
    output      logic [1:0]  channel_select_pins_oe,
    input  wire logic [3:0]  clk_toggle_active,
    input  wire logic [3:0]  clk_common_mode_high,
    output      logic [1:0]  route_sel,
    output      logic        route_valid,
    output      logic        power_down,
    output      logic [15:0] eq_gain,
    output      logic [1:0]  pll_bandwidth,
    input  wire logic        link_clk,
    input  wire logic [2:0]  rx_lane,
    output      logic [2:0]  tx_lane
);
    tisp_sys_t  s, next_s;
    tisp_link_t l, next_l;
    logic [3:0] act;
    logic       hw, auto_m, link_rst;
    logic [1:0] man;
    logic [2:0] err_pulse, clr;

    function automatic logic [1:0] prio(input logic [3:0] a);
        if (a[0]) return 2'h0;
        else if (a[1]) return 2'h1;
        else if (a[2]) return 2'h2;
        else return 2'h3;
    endfunction

    function automatic logic [7:0] rd_reg(input tisp_sys_t x, input logic [7:0] a, input logic sw_auto);
        unique case (a)
            REG_CTRL: rd_reg = sw_auto ? {x.ctrl[7:2], x.sel} : x.ctrl;
            REG_CFG:  rd_reg = x.cfg;
            REG_EQAB: rd_reg = x.eq_ab;
            REG_EQCD: rd_reg = x.eq_cd;
            REG_TPG:  rd_reg = x.tpg;
            REG_ERR0: rd_reg = x.errcnt[0];
            REG_ERR1: rd_reg = x.errcnt[1];
            REG_ERR2: rd_reg = x.errcnt[2];
            REG_PLL:  rd_reg = x.pll;
            default:  rd_reg = 8'h00;
        endcase
    endfunction

    // Selection source: pins after reset, control register once hardware-select is cleared.
    assign hw     = s.ctrl[CTRL_HWSEL_BIT];
    assign auto_m = hw ? s.auto_s2 : s.ctrl[CTRL_AUTO_BIT];
    assign man    = hw ? s.chsel_s2 : s.ctrl[1:0];
    assign err_pulse = s.tg_s2 ^ s.tg_d;

    always_comb begin
        logic [3:0] a;
        logic       rise, fall, start, stop, sw_auto;
        next_s  = s;
        a       = 4'h0;
        clr     = 3'h0;
        sw_auto = ~hw & s.ctrl[CTRL_AUTO_BIT];
        rise    = s.scl_s2 & ~s.scl_d;
        fall    = ~s.scl_s2 & s.scl_d;
        start   = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
        stop    = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;
        next_s.scl_s1 = scl;
        next_s.scl_s2 = s.scl_s1;
        next_s.scl_d  = s.scl_s2;
        next_s.sda_s1 = sda_in;
        next_s.sda_s2 = s.sda_s1;
        next_s.sda_d  = s.sda_s2;
        next_s.auto_s1  = auto_select_pin;
        next_s.auto_s2  = s.auto_s1;
        next_s.pd_s1    = power_down_pin;
        next_s.pd_s2    = s.pd_s1;
        next_s.chsel_s1 = channel_select_pins_in;
        next_s.chsel_s2 = s.chsel_s1;
        next_s.act_s1   = clk_toggle_active;
        next_s.act_s2   = s.act_s1;
        next_s.cm_s1    = clk_common_mode_high;
        next_s.cm_s2    = s.cm_s1;
        next_s.tg_s1    = l.err_tg;
        next_s.tg_s2    = s.tg_s1;
        next_s.tg_d     = s.tg_s2;

        // A high common-mode level means nothing drives the input.
        a = s.cfg[CFG_ACT_BIT] ? ~s.cm_s2 : s.act_s2;
        for (int i = 0; i < 4; i++) begin
            if (i >= NUM_CH) begin
                a[i] = 1'b0;
            end
        end
        act = a;
        if (NUM_CH == 1) begin
            next_s.sel       = 2'h0;
            next_s.sel_valid = 1'b1;
        end else if (auto_m) begin
            next_s.sel       = prio(a);
            next_s.sel_valid = |a;
        end else begin
            next_s.sel       = (NUM_CH == 2) ? {1'b0, man[0]} : man;
            next_s.sel_valid = 1'b1;
        end
        next_s.pd = s.pd_s2 | s.ctrl[CTRL_PD_BIT];
        // The pins are released while powered down, so their level floats there.
        next_s.chsel_oe  = hw & s.auto_s2 & ~next_s.pd & (NUM_CH > 1);
        next_s.chsel_out = next_s.sel;

        if (start) begin
            next_s.st     = I_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.sda_oe = 1'b0;
        end else if (stop) begin
            next_s.st     = I_IDLE;
            next_s.sda_oe = 1'b0;
        end else if (rise) begin
            unique case (s.st)
                I_ADDR, I_REG, I_WDATA: begin
                    next_s.sh     = {s.sh[6:0], s.sda_s2};
                    next_s.bitcnt = s.bitcnt + 4'h1;
                end
                I_RDATA: next_s.bitcnt = s.bitcnt + 4'h1;
                I_MACK: begin
                    // The byte is handed over at the acknowledge clock, which ends the read.
                    for (int i = 0; i < 3; i++) begin
                        clr[i] = (s.ptr == REG_ERR0 + 8'(i));
                    end
                    next_s.nack = s.sda_s2;
                    next_s.ptr  = s.ptr + 8'h01;
                end
                default: next_s.st = s.st;
            endcase
        end else if (fall) begin
            unique case (s.st)
                I_ADDR: if (s.bitcnt == 4'h8) begin
                    next_s.bitcnt = 4'h0;
                    if (s.sh[7:1] == I2C_ADDR) begin
                        next_s.rw     = s.sh[0];
                        next_s.sda_oe = 1'b1;
                        next_s.st     = I_AACK;
                    end else begin
                        next_s.st = I_IDLE;
                    end
                end
                I_AACK: begin
                    next_s.bitcnt = 4'h0;
                    if (s.rw) begin
                        next_s.sh     = rd_reg(s, s.ptr, sw_auto);
                        next_s.sda_oe = ~next_s.sh[7];
                        next_s.st     = I_RDATA;
                    end else begin
                        next_s.sda_oe = 1'b0;
                        next_s.st     = I_REG;
                    end
                end
                I_REG: if (s.bitcnt == 4'h8) begin
                    next_s.ptr    = s.sh;
                    next_s.sda_oe = 1'b1;
                    next_s.st     = I_REGACK;
                end
                I_REGACK, I_WACK: begin
                    next_s.sda_oe = 1'b0;
                    next_s.bitcnt = 4'h0;
                    next_s.st     = I_WDATA;
                end
                I_WDATA: if (s.bitcnt == 4'h8) begin
                    unique case (s.ptr)
                        // Channel bits stay status-only while software auto mode is on.
                        REG_CTRL: next_s.ctrl = sw_auto ? {s.sh[7:2], s.ctrl[1:0]} : s.sh;
                        REG_CFG:  next_s.cfg   = s.sh;
                        REG_EQAB: next_s.eq_ab = s.sh;
                        REG_EQCD: next_s.eq_cd = s.sh;
                        REG_TPG:  next_s.tpg   = s.sh;
                        REG_PLL:  next_s.pll   = s.sh;
                        default:  next_s.pll   = s.pll;
                    endcase
                    next_s.ptr    = s.ptr + 8'h01;
                    next_s.sda_oe = 1'b1;
                    next_s.st     = I_WACK;
                end
                I_RDATA: begin
                    if (s.bitcnt == 4'h8) begin
                        next_s.sda_oe = 1'b0;
                        next_s.st     = I_MACK;
                    end else begin
                        next_s.sh     = {s.sh[6:0], 1'b0};
                        next_s.sda_oe = ~s.sh[6];
                    end
                end
                I_MACK: begin
                    next_s.bitcnt = 4'h0;
                    if (s.nack) begin
                        next_s.st = I_IDLE;
                    end else begin
                        next_s.sh     = rd_reg(s, s.ptr, sw_auto);
                        next_s.sda_oe = ~next_s.sh[7];
                        next_s.st     = I_RDATA;
                    end
                end
                default: next_s.st = s.st;
            endcase
        end

        // An error arriving with the clear is kept, so the count restarts at one.
        for (int i = 0; i < 3; i++) begin
            if (clr[i]) begin
                next_s.errcnt[i] = {7'h00, err_pulse[i]};
            end else if (err_pulse[i] && s.errcnt[i] != ERR_MAX) begin
                next_s.errcnt[i] = s.errcnt[i] + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s       <= '0;
            s.st    <= I_IDLE;
            s.ctrl  <= CTRL_RST;
            s.cfg   <= CFG_RST;
            s.eq_ab <= EQ_RST;
            s.eq_cd <= EQ_RST;
            s.tpg   <= TPG_RST;
            s.pll   <= PLL_RST;
        end else begin
            s <= next_s;
        end
    end

    // Link domain: mode and enable are levels; the mode is taken only once two samples agree.
    assign link_rst = ~l.rs[1];

    always_comb begin
        logic pat;
        next_l    = l;
        pat       = 1'b0;
        next_l.rs = {l.rs[0], 1'b1};
        next_l.mode_s1 = s.tpg[1:0];
        next_l.mode_s2 = l.mode_s1;
        next_l.mode_d  = l.mode_s2;
        next_l.en_s1   = s.tpg[TPG_ERR_EN_BIT];
        next_l.en_s2   = l.en_s1;
        if (l.mode_s2 == l.mode_d) begin
            next_l.mode = l.mode_d;
        end
        next_l.prbs   = {l.prbs[5:0], l.prbs[6] ^ l.prbs[5]};
        next_l.lowcnt = (l.lowcnt == LOW_LAST) ? 4'h0 : l.lowcnt + 4'h1;
        next_l.hf     = ~l.hf;
        unique case (l.mode)
            GEN_NORMAL: pat = 1'b0;
            GEN_PRBS:   pat = l.prbs[6] ^ l.prbs[5];
            GEN_LOW:    pat = (l.lowcnt >= LOW_HALF);
            GEN_HIGH:   pat = l.hf;
        endcase
        next_l.tx = (l.mode == GEN_NORMAL) ? rx_lane : {3{pat}};
        // Self-synchronising check: each bit must match the taps of the last seven.
        for (int i = 0; i < 3; i++) begin
            next_l.hist[i] = {l.hist[i][5:0], rx_lane[i]};
            if (l.en_s2 && (rx_lane[i] != (l.hist[i][6] ^ l.hist[i][5]))) begin
                next_l.err_tg[i] = ~l.err_tg[i];
            end
        end
        if (link_rst) begin
            next_l      = '0;
            // The release chain must keep shifting in ones, or the link logic never leaves reset.
            next_l.rs   = {l.rs[0], 1'b1};
            next_l.prbs = PRBS_SEED;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            l <= '0;
        end else begin
            l <= next_l;
        end
    end

    assign sda_out                 = s.sda_o;
    assign sda_oe                  = s.sda_oe;
    assign channel_select_pins_out = s.chsel_out;
    assign channel_select_pins_oe  = {2{s.chsel_oe}};
    assign route_sel               = s.sel;
    assign route_valid             = s.sel_valid;
    assign power_down              = s.pd;
    assign eq_gain                 = {s.eq_cd, s.eq_ab};
    assign pll_bandwidth           = s.pll[1:0];
    assign tx_lane                 = l.tx;

    sequence s_read_ends(int i);
        clr[i] && !err_pulse[i];
    endsequence

    a_err_saturates: assert property (@(posedge clk) disable iff (!rst_n)
        s.errcnt[0] == ERR_MAX && !clr[0] |=> s.errcnt[0] == ERR_MAX)
        else $error("error counter wrapped past its maximum");
    a_err_steps_one: assert property (@(posedge clk) disable iff (!rst_n)
        err_pulse[1] && !clr[1] && s.errcnt[1] != ERR_MAX |=> s.errcnt[1] == $past(s.errcnt[1]) + 8'h01)
        else $error("error counter did not step by one");
    a_read_clears: assert property (@(posedge clk) disable iff (!rst_n)
        s_read_ends(2) |=> s.errcnt[2] == 8'h00)
        else $error("error counter not cleared after read");
    a_auto_picks_a: assert property (@(posedge clk) disable iff (!rst_n)
        auto_m && act[0] && NUM_CH > 1 |=> route_sel == 2'h0 && route_valid)
        else $error("auto mode did not pick channel A");
    a_auto_none_idle: assert property (@(posedge clk) disable iff (!rst_n)
        auto_m && act == 4'h0 && NUM_CH > 1 |=> !route_valid)
        else $error("output active with no active channel");
    a_pins_manual: assert property (@(posedge clk) disable iff (!rst_n)
        hw && !s.auto_s2 && NUM_CH == 4 |=> route_sel == $past(s.chsel_s2) && !channel_select_pins_oe[0])
        else $error("manual pin selection not followed");
    a_pins_report: assert property (@(posedge clk) disable iff (!rst_n)
        channel_select_pins_oe[0] |-> channel_select_pins_out == route_sel)
        else $error("select pins do not report the routed channel");
    a_sw_owns_mux: assert property (@(posedge clk) disable iff (!rst_n)
        !hw && !s.ctrl[CTRL_AUTO_BIT] && NUM_CH == 4 ##1 !hw && !s.ctrl[CTRL_AUTO_BIT]
        |-> route_sel == $past(s.ctrl[1:0]))
        else $error("software selection not routed");
    a_count_gated: assert property (@(posedge link_clk) disable iff (!rst_n)
        !l.en_s2 |=> l.err_tg == $past(l.err_tg))
        else $error("errors counted while counting disabled");
endmodule // tisp_top

// *** testbench/tisp_tmds_src.sv ***
/*
 * Model of the TMDS source on the selected input: a free-running pixel clock and PRBS7 data on all three lanes.
 * Assumes the bench asks for a broken lane 1 only while it tests the error counters.
 */
`timescale 1ns/1ps
module tisp_tmds_src (
    output logic       link_clk,
    output logic [2:0] rx_lane,
    input  wire logic  bad_lane1
);
    logic [6:0] prbs = 7'h7f;
    logic       nb;

    assign nb = prbs[5] ^ prbs[6];

    // A TMDS clock runs continuously, so it is not gated between frames.
    initial begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end

    // Data is launched on the rising edge so that the receiver sees it settled a full period later.
    initial rx_lane = 3'h0;
    always @(posedge link_clk) begin
        prbs    <= {prbs[5:0], nb};
        rx_lane <= {nb, bad_lane1 | nb, nb};
    end
endmodule // tisp_tmds_src

// *** testbench/tb_tisp_top.sv ***
/*
 * Self-checking bench for tisp_top: serial register master, selection pins and the link source.
 * Assumes the default serial address and four input channels.
 */
`timescale 1ns/1ps
module tb_tisp_top
    import tisp_pkg::*;
;
    localparam logic [6:0] DEV = 7'h50;
    logic        clk, rst_n, scl_m, sda_m, auto_pin, pd_pin, bad1, link_clk;
    logic        sda_out, sda_oe, route_valid, power_down;
    logic [1:0]  csel_drv, csel_line, pins_out, pins_oe, route_sel, pll_bw;
    logic [3:0]  tog, cm;
    logic [15:0] eq_gain, obs;
    logic [2:0]  rx_lane, tx_lane;
    logic [7:0]  q;
    logic [31:0] r;
    logic [15:0] exp_q[$];
    logic [31:0] lfsr_s = 32'h91ca;
    logic [7:0]  rst_a[6] = '{REG_EQAB, REG_EQCD, REG_TPG, REG_ERR0, REG_PLL, 8'h20};
    logic [7:0]  rst_v[6] = '{EQ_RST, EQ_RST, TPG_RST, 8'h00, PLL_RST, 8'h00};
    int          fails = 0;
    int          n_compared = 0;
    event        got;
    wire         sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

    assign csel_line = pins_oe[0] ? pins_out : csel_drv;

    tisp_top dut_u (
        .clk(clk), .rst_n(rst_n), .scl(scl_m), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .auto_select_pin(auto_pin), .power_down_pin(pd_pin), .channel_select_pins_in(csel_line),
        .channel_select_pins_out(pins_out), .channel_select_pins_oe(pins_oe), .clk_toggle_active(tog),
        .clk_common_mode_high(cm), .route_sel(route_sel), .route_valid(route_valid),
        .power_down(power_down), .eq_gain(eq_gain), .pll_bandwidth(pll_bw), .link_clk(link_clk),
        .rx_lane(rx_lane), .tx_lane(tx_lane)
    );
    tisp_tmds_src src_u (.link_clk(link_clk), .rx_lane(rx_lane), .bad_lane1(bad1));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        lfsr_s = {lfsr_s[30:0], lfsr_s[31] ^ lfsr_s[21] ^ lfsr_s[1] ^ lfsr_s[0]};
        return lfsr_s;
    endfunction

    task automatic test_done();
        if (fails == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check_result(input logic [15:0] e, input logic [15:0] o);
        n_compared++;
        if (o !== e) begin
            fails++;
            $display("[FAIL] %0t result %h expected %h", $time, o, e);
        end
    endtask

    // The wait to the next falling edge keeps the observation stable until the watcher has taken it.
    task automatic note(input logic [15:0] e, input logic [15:0] o);
        exp_q.push_back(e);
        obs = o;
        -> got;
        @(negedge clk);
    endtask

    initial forever begin
        @(got);
        check_result(exp_q.pop_front(), obs);
    end

    task automatic hp();
        repeat (10) @(negedge clk);
    endtask

    task automatic bitx(input logic b, output logic s);
        repeat (5) @(negedge clk);
        sda_m = b;
        hp();
        scl_m = 1'b1;
        hp();
        s = sda_line;
        scl_m = 1'b0;
    endtask

    task automatic start();
        repeat (5) @(negedge clk);
        sda_m = 1'b1;
        hp();
        scl_m = 1'b1;
        hp();
        sda_m = 1'b0;
        hp();
        scl_m = 1'b0;
    endtask

    task automatic stop();
        repeat (5) @(negedge clk);
        sda_m = 1'b0;
        hp();
        scl_m = 1'b1;
        hp();
        sda_m = 1'b1;
        hp();
    endtask

    task automatic xbyte(input logic [7:0] d, input logic m9, output logic [7:0] s);
        logic a;
        for (int i = 7; i >= 0; i--) bitx(d[i], s[i]);
        bitx(m9, a);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] s;
        start();
        xbyte({DEV, 1'b0}, 1'b1, s);
        xbyte(a, 1'b1, s);
        xbyte(d, 1'b1, s);
        stop();
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] s);
        start();
        xbyte({DEV, 1'b0}, 1'b1, s);
        xbyte(a, 1'b1, s);
        start();
        xbyte({DEV, 1'b1}, 1'b1, s);
        xbyte(8'hff, 1'b1, s);
        stop();
    endtask

    task automatic exp_rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] s;
        rd(a, s);
        note({8'h00, e}, {8'h00, s});
    endtask

    task automatic sel_check(input logic [3:0] act);
        logic [1:0] e;
        e = 2'h0;
        for (int c = 3; c >= 0; c--) if (act[c]) e = 2'(c);
        note(act != 4'h0 ? {9'h0, 1'b1, e, e, 2'h3} : 16'h0003,
             act != 4'h0 ? {9'h0, route_valid, route_sel, pins_out, pins_oe} : {13'h0, route_valid, pins_oe});
    endtask

    // Sixteen bits are enough to see a full period of both toggle patterns, the PRBS7 recurrence and the lane-to-lane agreement.
    task automatic pat(input logic [1:0] m);
        logic [15:0] c, x, o;
        logic        d;
        d = 1'b0;
        wr(REG_TPG, {6'h0, m});
        repeat (12) @(negedge link_clk);
        for (int i = 0; i < 16; i++) begin
            @(negedge link_clk);
            c = {c[14:0], tx_lane[0]};
            x = {x[14:0], rx_lane[0]};
            d = d | (tx_lane[1] ^ tx_lane[0]) | (tx_lane[2] ^ tx_lane[0]);
        end
        case (m)
            GEN_NORMAL: o = {1'b0, c[14:0] ^ x[15:1]};
            GEN_PRBS:   o = {6'h0, c == 16'h0, c[8:0] ^ c[14:6] ^ c[15:7]};
            GEN_LOW:    o = {2'h0, c[15:10] ^ c[5:0], 4'($countones(c[9:0])), 4'($countones(c[9:0] ^ c[10:1]))};
            default:    o = {1'b0, c[14:0] ^ c[15:1]};
        endcase
        @(negedge clk);
        note(m == GEN_LOW ? 16'h0052 : (m == GEN_HIGH ? 16'h7fff : 16'h0000), o | {d, 15'h0});
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fails++;
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        scl_m = 1'b1;
        sda_m = 1'b1;
        auto_pin = 1'b1;
        pd_pin = 1'b0;
        bad1 = 1'b0;
        csel_drv = 2'h0;
        tog = 4'h0;
        cm = 4'hf;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (20) @(negedge clk);
        note(16'hcccc, eq_gain);
        note(16'h0000, {14'h0, pll_bw});
        foreach (rst_a[i]) exp_rd(rst_a[i], rst_v[i]);
        for (int i = 0; i < 4; i++) begin
            wr(REG_PLL, {6'b000100, 2'(i ^ 1)});
            note({14'h0, 2'(i ^ 1)}, {14'h0, pll_bw});
        end
        exp_rd(REG_PLL, 8'h12);
        r = rnd();
        wr(REG_EQAB, r[7:0]);
        wr(REG_EQCD, r[15:8]);
        note(r[15:0], eq_gain);
        exp_rd(REG_EQCD, r[15:8]);
        for (int m = 0; m < 2; m++) begin
            wr(REG_CFG, m != 0 ? CFG_RST : 8'h00);
            for (int k = 0; k < 6; k++) begin
                r = rnd();
                if (k == 0) r[3:0] = 4'h0;
                tog = m != 0 ? r[7:4] : r[3:0];
                cm = m != 0 ? ~r[3:0] : r[7:4];
                repeat (8) @(negedge clk);
                sel_check(r[3:0]);
            end
        end
        pd_pin = 1'b1;
        repeat (8) @(negedge clk);
        note(16'h0004, {13'h0, power_down, pins_oe});
        pd_pin = 1'b0;
        auto_pin = 1'b0;
        for (int c = 0; c < 4; c++) begin
            csel_drv = 2'(c);
            repeat (8) @(negedge clk);
            note({12'h0, 2'(c), 2'h0}, {12'h0, route_sel, pins_oe});
        end
        for (int c = 0; c < 4; c++) begin
            csel_drv = ~2'(c);
            wr(REG_CTRL, {6'h0, 2'(c)});
            note({14'h0, 2'(c)}, {14'h0, route_sel});
            exp_rd(REG_CTRL, {6'h0, 2'(c)});
        end
        cm = 4'hb;
        wr(REG_CTRL, 8'h04);
        wr(REG_CTRL, 8'h05);
        note(16'h0002, {14'h0, route_sel});
        exp_rd(REG_CTRL, 8'h06);
        wr(REG_TPG, 8'h04);
        repeat (20) @(negedge link_clk);
        for (int i = 0; i < 3; i++) rd(REG_ERR0 + 8'(i), q);
        bad1 = 1'b1;
        repeat (300) @(negedge link_clk);
        exp_rd(REG_ERR0, 8'h00);
        exp_rd(REG_ERR2, 8'h00);
        wr(REG_TPG, 8'h00);
        exp_rd(REG_ERR1, ERR_MAX);
        exp_rd(REG_ERR1, 8'h00);
        bad1 = 1'b0;
        pat(GEN_PRBS);
        pat(GEN_LOW);
        pat(GEN_NORMAL);
        pat(GEN_HIGH);
        pat(GEN_NORMAL);
        test_done();
    end
endmodule // tb_tisp_top
